// ### inc/wpvr_pkg.sv
// Purpose: Constants for the write-protect and voltage/reset register bank
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses = 4 x index
// Notes:   Offsets below are register indices; byte address is index * 4
package wpvr_pkg;
	// Register indices
	localparam logic [5:0] IDX_CLK_MODE_A   = 6'h06;
	localparam logic [5:0] IDX_CLK_MODE_B   = 6'h07;
	localparam logic [5:0] IDX_WRITE_PROT   = 6'h0a;
	localparam logic [5:0] IDX_CLK_MODE_C   = 6'h0c;
	localparam logic [5:0] IDX_PERIPH_CLK   = 6'h12;
	localparam logic [5:0] IDX_RESET_SRC    = 6'h18;
	localparam logic [5:0] IDX_DET_ENABLE   = 6'h1a;
	localparam logic [5:0] IDX_MULT_CTRL    = 6'h1c;
	localparam logic [5:0] IDX_OSC_ADJUST   = 6'h1d;
	localparam logic [5:0] IDX_VOLT_IRQ_EN  = 6'h26;
	localparam logic [5:0] IDX_LEVEL_SEL    = 6'h28;
	localparam logic [5:0] IDX_MON0_CTRL    = 6'h2a;
	localparam logic [5:0] IDX_MON1_CTRL    = 6'h2b;
	localparam logic [5:0] IDX_MON2_CTRL    = 6'h2c;
	localparam logic [5:0] IDX_PROG_GUARD   = 6'h2d;
	// Write-protect bit positions
	localparam int PROT_CLK_BIT   = 0;
	localparam int PROT_VOLT_BIT  = 3;
	localparam int PROT_GUARD_BIT = 6;
	// Detector enable bit positions
	localparam int DET0_EN_BIT = 5;
	localparam int DET1_EN_BIT = 6;
	localparam int DET2_EN_BIT = 7;
	// Monitor control: bit 0 enables monitor, bit 1 selects reset (else irq) on monitors 1 and 2
	localparam int MON_EN_BIT    = 0;
	localparam int MON_RESET_BIT = 1;
	// Reset source bit positions; bit 7 is cold/warm flag
	localparam int SRC_PIN_BIT   = 0;
	localparam int SRC_MON0_BIT  = 1;
	localparam int SRC_MON1_BIT  = 2;
	localparam int SRC_MON2_BIT  = 3;
	localparam int SRC_POR_BIT   = 4;
	localparam int SRC_OSC_BIT   = 5;
	localparam int SRC_WDOG_BIT  = 6;
	localparam int SRC_WARM_BIT  = 7;
	// Reset values
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_CLK_MODE_B = 8'h20;
	localparam logic [7:0] RST_RESET_SRC  = 8'h10;
	// Recorded source codes: cause bit plus warm flag; software code is the warm flag alone
	localparam logic [7:0] SRC_CODE_PIN   = 8'h81;
	localparam logic [7:0] SRC_CODE_OSC   = 8'ha0;
	localparam logic [7:0] SRC_CODE_WDOG  = 8'hc0;
	localparam logic [7:0] SRC_CODE_SW    = 8'h80;
	// Software reset request key written to reset source register
	localparam logic [7:0] SW_RESET_KEY   = 8'ha5;
endpackage

// ### src/wpvr_guard_reg.sv
// Purpose: One 8-bit register whose write is gated by an unlock level
// Assumes: Same clock as the bus; write strobe already decoded
// Notes:   Locked writes leave the content unchanged
`timescale 1ns/1ps
`default_nettype none
module wpvr_guard_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic       clk_i,     // System clock
	input  wire logic       rst_i,     // Synchronous reset
	input  wire logic       wr_i,      // Decoded write strobe
	input  wire logic       unlock_i,  // Covering protect bit
	input  wire logic [7:0] data_i,    // Write data
	output logic      [7:0] value_o    // Stored value
);
	logic [7:0] value_r; // Held contents

	// Store only while unlocked
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			value_r <= RESET_VAL;
		end else if (wr_i && unlock_i) begin
			value_r <= data_i;
		end
	end

	assign value_o = value_r;
endmodule
`default_nettype wire

// ### src/wpvr_regs.sv
// Purpose: Protect, voltage-detector and reset-source register bank
// Assumes: Classic Wishbone, ack one cycle after strobe, 25 MHz clock
// Notes:   Reset causes arrive as synchronised-in levels on cause inputs
`timescale 1ns/1ps
`default_nettype none
module wpvr_regs (
	input  wire logic        clk_i,          // System clock
	input  wire logic        rst_i,          // Synchronous reset (warm)
	input  wire logic        por_i,          // Power-on reset event pin
	input  wire logic        pin_reset_i,    // External reset pin event
	input  wire logic        osc_stop_i,     // Oscillation stop detected
	input  wire logic        wdog_expire_i,  // Watchdog expired
	input  wire logic [2:0]  volt_low_i,     // Comparator outputs, circuits 0..2
	input  wire logic        wb_cyc_i,       // Wishbone cycle
	input  wire logic        wb_stb_i,       // Wishbone strobe
	input  wire logic        wb_we_i,        // Wishbone write
	input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
	input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address
	input  wire logic [31:0] wb_dat_i,       // Wishbone write data
	output logic      [31:0] wb_dat_o,       // Wishbone read data
	output logic             wb_ack_o,       // Wishbone acknowledge
	output logic      [2:0]  det_enable_o,   // Detection circuit enables
	output logic             volt_reset_req_o, // Voltage reset request
	output logic             volt_irq_o,     // Voltage detection interrupt
	output logic             sw_reset_req_o, // Software reset request pulse
	output logic      [7:0]  clk_mode_a_o,   // Clock mode reg a
	output logic      [7:0]  clk_mode_b_o,   // Clock mode reg b
	output logic      [7:0]  clk_mode_c_o,   // Clock mode reg c
	output logic      [7:0]  mult_ctrl_o,    // Multiplier control
	output logic      [7:0]  periph_clk_o,   // Peripheral clock select
	output logic      [7:0]  osc_adjust_o,   // Oscillator adjust
	output logic      [7:0]  level_sel_o,    // Detection level select
	output logic      [7:0]  prog_guard_o    // Program guard control
);
	localparam int NREG = 13; // Guarded register count

	// Input synchronisers: por, pin, osc, wdog, volt[2:0]
	logic [6:0] sync1_r;   // First stage
	logic [6:0] sync2_r;   // Second stage
	logic [6:0] prev_r;    // Edge detect history
	logic [6:0] rise;      // Rising edges of causes

	logic       ack_r;       // Ack flop
	logic [31:0] rdata_r;    // Read data flop
	logic [7:0] prot_r;      // Write protect register
	logic [7:0] src_r;       // Reset source flags
	logic       sw_req_r;    // Software reset pulse
	logic       req;         // New request this cycle
	logic       wr;          // Write taken
	logic [5:0] idx;         // Register index
	logic [7:0] wd;          // Write byte lane 0
	logic [7:0] rd;          // Read mux value

	logic [NREG-1:0] reg_wr;       // Write strobe of each guarded register
	logic [NREG-1:0] reg_unl;      // Unlock of each guarded register
	logic [7:0]  reg_val  [NREG];  // Value of each guarded register
	logic [2:0]  mon_on;           // Monitor armed: circuit and monitor on
	logic [2:0]  mon_rst;          // Monitor routes to reset
	logic [2:0]  volt_hit;         // Armed monitor sees a low level
	logic [2:0]  volt_cause;       // New low level on a reset monitor
	logic [7:0]  src_nxt;          // Next reset source flags

	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr  = req && wb_we_i && wb_sel_i[0];
	assign idx = wb_adr_i[7:2];
	assign wd  = wb_dat_i[7:0];

	// Cause lines and comparators come from outside the clock domain;
	// only the second stage feeds logic, the first is read by nothing else
	// First synchroniser stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 7'h00;
		end else begin
			sync1_r <= {volt_low_i, wdog_expire_i, osc_stop_i, pin_reset_i, por_i};
		end
	end

	// Second synchroniser stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync2_r <= 7'h00;
		end else begin
			sync2_r <= sync1_r;
		end
	end

	// Edge history resets low, the idle level of every cause line,
	// so no false edge follows reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_r <= 7'h00;
		end else begin
			prev_r <= sync2_r;
		end
	end
	assign rise = sync2_r & ~prev_r;

	// Slot numbering of the guarded registers, used by every array below:
	//   slots 0 to 5  : clock group, opened by protect bit 0
	//     0 clock mode a, 1 clock mode b (own reset value), 2 clock mode c
	//     3 multiplier control, 4 peripheral clock select, 5 oscillator adjust
	//   slots 6 to 11 : voltage group, opened by protect bit 3
	//     6 detector enables, 7 interrupt enables, 8 level select
	//     9 to 11 monitor 0 to 2 control
	//   slot 12       : program guard, opened by protect bit 6
	// Protect and reset source live outside the slots and are never locked
	// Write strobe decode: at most one match, unmapped indices strobe nothing
	// A write with lane 0 deselected never reaches a strobe
	always_comb begin
		reg_wr = {NREG{1'b0}};
		if (idx == wpvr_pkg::IDX_CLK_MODE_A) begin
			reg_wr[0] = wr;
		end else if (idx == wpvr_pkg::IDX_CLK_MODE_B) begin
			reg_wr[1] = wr;
		end else if (idx == wpvr_pkg::IDX_CLK_MODE_C) begin
			reg_wr[2] = wr;
		end else if (idx == wpvr_pkg::IDX_MULT_CTRL) begin
			reg_wr[3] = wr;
		end else if (idx == wpvr_pkg::IDX_PERIPH_CLK) begin
			reg_wr[4] = wr;
		end else if (idx == wpvr_pkg::IDX_OSC_ADJUST) begin
			reg_wr[5] = wr;
		end else if (idx == wpvr_pkg::IDX_DET_ENABLE) begin
			reg_wr[6] = wr;
		end else if (idx == wpvr_pkg::IDX_VOLT_IRQ_EN) begin
			reg_wr[7] = wr;
		end else if (idx == wpvr_pkg::IDX_LEVEL_SEL) begin
			reg_wr[8] = wr;
		end else if (idx == wpvr_pkg::IDX_MON0_CTRL) begin
			reg_wr[9] = wr;
		end else if (idx == wpvr_pkg::IDX_MON1_CTRL) begin
			reg_wr[10] = wr;
		end else if (idx == wpvr_pkg::IDX_MON2_CTRL) begin
			reg_wr[11] = wr;
		end else if (idx == wpvr_pkg::IDX_PROG_GUARD) begin
			reg_wr[12] = wr;
		end
	end

	// Unlock levels per group
	assign reg_unl[5:0]  = {6{prot_r[wpvr_pkg::PROT_CLK_BIT]}};
	assign reg_unl[11:6] = {6{prot_r[wpvr_pkg::PROT_VOLT_BIT]}};
	assign reg_unl[12]   = prot_r[wpvr_pkg::PROT_GUARD_BIT];

	// One gated register per guarded location
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			wpvr_guard_reg #(
				.RESET_VAL (g == 1 ? wpvr_pkg::RST_CLK_MODE_B : wpvr_pkg::RST_ZERO)
			) u_reg (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.wr_i     (reg_wr[g]),
				.unlock_i (reg_unl[g]),
				.data_i   (wd),
				.value_o  (reg_val[g])
			);
		end
	endgenerate

	// Write protect register, always writable
	// Clearing a bit locks its group again from the next cycle on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prot_r <= wpvr_pkg::RST_ZERO;
		end else if (wr && idx == wpvr_pkg::IDX_WRITE_PROT) begin
			prot_r <= wd;
		end
	end

	// Reset source flags hold no reset of their own: the warm reset must not
	// wipe the record that software reads after restart. Until the first
	// recorded cause of any kind the flags are unknown, so a power-on event must come first.
	// Causes landing in one cycle resolve by the fixed order below.
	// Warm flag set on every cause but power-on, telling cold from warm
	assign volt_cause = rise[6:4] & mon_on & mon_rst;
	always_comb begin
		src_nxt = src_r;
		if (rise[0]) begin
			src_nxt = wpvr_pkg::RST_RESET_SRC; // cold start
		end else if (rise[1]) begin
			src_nxt = wpvr_pkg::SRC_CODE_PIN;  // pin, warm
		end else if (volt_cause != 3'h0) begin
			src_nxt = wpvr_pkg::RST_ZERO;      // monitors, warm
			src_nxt[wpvr_pkg::SRC_WARM_BIT] = 1'b1;
			src_nxt[wpvr_pkg::SRC_MON2_BIT:wpvr_pkg::SRC_MON0_BIT] = volt_cause;
		end else if (rise[2]) begin
			src_nxt = wpvr_pkg::SRC_CODE_OSC;  // oscillation stop
		end else if (rise[3]) begin
			src_nxt = wpvr_pkg::SRC_CODE_WDOG; // watchdog
		end else if (sw_req_r) begin
			src_nxt = wpvr_pkg::SRC_CODE_SW;   // software
		end
	end

	// Source flag storage, free of the warm reset on purpose
	always_ff @(posedge clk_i) begin
		src_r <= src_nxt;
	end

	// Software reset request on key write to source register
	// The key makes a single-cycle pulse; any other value is ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_req_r <= 1'b0;
		end else begin
			sw_req_r <= wr && idx == wpvr_pkg::IDX_RESET_SRC && wd == wpvr_pkg::SW_RESET_KEY;
		end
	end

	// Detector enables and event routing
	assign det_enable_o[0] = reg_val[6][wpvr_pkg::DET0_EN_BIT];
	assign det_enable_o[1] = reg_val[6][wpvr_pkg::DET1_EN_BIT];
	assign det_enable_o[2] = reg_val[6][wpvr_pkg::DET2_EN_BIT];
	// Monitor armed when its circuit and its monitor are both on
	assign mon_on[0]  = det_enable_o[0] && reg_val[9][wpvr_pkg::MON_EN_BIT];
	assign mon_on[1]  = det_enable_o[1] && reg_val[10][wpvr_pkg::MON_EN_BIT];
	assign mon_on[2]  = det_enable_o[2] && reg_val[11][wpvr_pkg::MON_EN_BIT];
	// Circuit 0 can only reset; circuits 1 and 2 choose reset or interrupt
	assign mon_rst[0] = 1'b1;
	assign mon_rst[1] = reg_val[10][wpvr_pkg::MON_RESET_BIT];
	assign mon_rst[2] = reg_val[11][wpvr_pkg::MON_RESET_BIT];
	// Requests are levels: they stand while the comparator stays low
	// and drop as soon as the circuit or monitor is switched off
	assign volt_hit         = mon_on & sync2_r[6:4];
	assign volt_reset_req_o = |(volt_hit & mon_rst);
	assign volt_irq_o       = |(volt_hit[2:1] & ~mon_rst[2:1]);

	// Read mux: one else-if chain over the map, unmapped indices read zero
	always_comb begin
		rd = wpvr_pkg::RST_ZERO;
		if (idx == wpvr_pkg::IDX_WRITE_PROT) begin
			rd = prot_r;
		end else if (idx == wpvr_pkg::IDX_RESET_SRC) begin
			rd = src_r;
		end else if (idx == wpvr_pkg::IDX_CLK_MODE_A) begin
			rd = reg_val[0];
		end else if (idx == wpvr_pkg::IDX_CLK_MODE_B) begin
			rd = reg_val[1];
		end else if (idx == wpvr_pkg::IDX_CLK_MODE_C) begin
			rd = reg_val[2];
		end else if (idx == wpvr_pkg::IDX_MULT_CTRL) begin
			rd = reg_val[3];
		end else if (idx == wpvr_pkg::IDX_PERIPH_CLK) begin
			rd = reg_val[4];
		end else if (idx == wpvr_pkg::IDX_OSC_ADJUST) begin
			rd = reg_val[5];
		end else if (idx == wpvr_pkg::IDX_DET_ENABLE) begin
			rd = reg_val[6];
		end else if (idx == wpvr_pkg::IDX_VOLT_IRQ_EN) begin
			rd = reg_val[7];
		end else if (idx == wpvr_pkg::IDX_LEVEL_SEL) begin
			rd = reg_val[8];
		end else if (idx == wpvr_pkg::IDX_MON0_CTRL) begin
			rd = reg_val[9];
		end else if (idx == wpvr_pkg::IDX_MON1_CTRL) begin
			rd = reg_val[10];
		end else if (idx == wpvr_pkg::IDX_MON2_CTRL) begin
			rd = reg_val[11];
		end else if (idx == wpvr_pkg::IDX_PROG_GUARD) begin
			rd = reg_val[12];
		end else begin
			rd = wpvr_pkg::RST_ZERO; // Unmapped
		end
	end

	// Bus handshake: a request is taken on the edge where cyc and stb are
	// high and ack is low; ack follows one cycle later for exactly one cycle,
	// so the request still held in the ack cycle is never taken twice.
	// Writes to a locked register are acknowledged but leave it alone.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// Read data captured on the taking edge, held until the next request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (req) begin
			rdata_r <= {24'h00_0000, rd};
		end
	end

	// Register values go straight out of the flops
	assign wb_ack_o       = ack_r;
	assign wb_dat_o       = rdata_r;
	assign sw_reset_req_o = sw_req_r;
	assign clk_mode_a_o   = reg_val[0];
	assign clk_mode_b_o   = reg_val[1];
	assign clk_mode_c_o   = reg_val[2];
	assign mult_ctrl_o    = reg_val[3];
	assign periph_clk_o   = reg_val[4];
	assign osc_adjust_o   = reg_val[5];
	assign level_sel_o    = reg_val[8];
	assign prog_guard_o   = reg_val[12];
endmodule
`default_nettype wire

// ### test/wpvr_regs_sva.sv
// Purpose: Port-level checker for the protect and voltage/reset register bank
// Assumes: Ack one cycle after a request; byte address is index * 4
// Notes:   Bound from the bench top, sees design ports only
`timescale 1ns/1ps
`default_nettype none
module wpvr_regs_sva (
	input  wire logic        clk_i,            // System clock
	input  wire logic        rst_i,            // Sync reset
	input  wire logic        wb_cyc_i,         // Bus cycle
	input  wire logic        wb_stb_i,         // Bus strobe
	input  wire logic        wb_we_i,          // Bus write
	input  wire logic [7:0]  wb_adr_i,         // Bus byte address
	input  wire logic [31:0] wb_dat_o,         // Read data
	input  wire logic        wb_ack_o,         // Acknowledge
	input  wire logic [2:0]  det_enable_o,     // Circuit enables
	input  wire logic        volt_reset_req_o, // Voltage reset request
	input  wire logic        volt_irq_o,       // Voltage interrupt
	input  wire logic        sw_reset_req_o,   // Software reset pulse
	input  wire logic [7:0]  clk_mode_a_o,     // Clock mode a
	input  wire logic [7:0]  prog_guard_o      // Program guard
);
	logic [7:0] wadr; // Address of a live write, else unused code
	assign wadr = (wb_cyc_i && wb_stb_i && wb_we_i) ? wb_adr_i : 8'hff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answer timing and shape
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read data not zero");
	// Guarded values move only after a write to their own address
	AST_CLKA_WR: assert property ($changed(clk_mode_a_o) |-> $past(rst_i) || $past(wadr) == 8'h18)
		else $error("clock mode a changed without write");
	AST_GUARD_WR: assert property ($changed(prog_guard_o) |-> $past(rst_i) || $past(wadr) == 8'hb4)
		else $error("program guard changed without write");
	AST_DET_WR: assert property ($changed(det_enable_o) |-> $past(rst_i) || $past(wadr) == 8'h68 || $past(wadr, 2) == 8'h68)
		else $error("enables changed without write");
	// Disabled circuits raise nothing
	AST_IRQ_EN: assert property (det_enable_o[2:1] == 2'b00 |-> !volt_irq_o)
		else $error("interrupt with circuits 1 and 2 off");
	AST_VRST_EN: assert property (det_enable_o == 3'b000 |-> !volt_reset_req_o)
		else $error("voltage reset with all circuits off");
	AST_SW_ONE: assert property (sw_reset_req_o |=> !sw_reset_req_o)
		else $error("software reset pulse too long");
endmodule
`default_nettype wire

// ### test/tb_wpvr_regs.sv
// Purpose: Self-checking bench for the protect and voltage/reset register bank
// Assumes: Ack one cycle after a request; byte address is index * 4
// Notes:   Expected values come from the register map
`timescale 1ns/1ps
`default_nettype none
module tb_wpvr_regs;
	logic        clk_i = 1'b0;         // 25 MHz clock
	logic        rst_i = 1'b1;         // Sync reset
	logic        por_i = 1'b0;         // Cause inputs
	logic        pin_reset_i = 1'b0;
	logic        osc_stop_i = 1'b0;
	logic        wdog_expire_i = 1'b0;
	logic [2:0]  volt_low_i = 3'h0;    // Comparators
	logic        wb_cyc_i = 1'b0;      // Bus request
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_sel_i = 4'h1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;             // Design outputs
	logic        wb_ack_o, volt_reset_req_o, volt_irq_o, sw_reset_req_o;
	logic [2:0]  det_enable_o;
	logic [7:0]  clk_mode_a_o, clk_mode_b_o, clk_mode_c_o, mult_ctrl_o;
	logic [7:0]  periph_clk_o, osc_adjust_o, level_sel_o, prog_guard_o;
	logic        sw_seen = 1'b0;       // Software pulse was seen
	logic [7:0]  q;                    // Last read data
	int          error_cnt = 0;
	int          checked = 0;
	wpvr_regs DUT (.clk_i, .rst_i, .por_i, .pin_reset_i, .osc_stop_i, .wdog_expire_i, .volt_low_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.det_enable_o, .volt_reset_req_o, .volt_irq_o, .sw_reset_req_o, .clk_mode_a_o, .clk_mode_b_o,
		.clk_mode_c_o, .mult_ctrl_o, .periph_clk_o, .osc_adjust_o, .level_sel_o, .prog_guard_o);
	// Clock and pulse catcher
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) if (sw_reset_req_o === 1'b1) sw_seen <= 1'b1;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One classic cycle, held until ack is seen
	task bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk({7'h0, wb_ack_o}, 8'h01);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task rd(input logic [5:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(q, e);
	endtask
	// Locked writes, reset values, unmapped read
	task t_lock;
		rd(wpvr_pkg::IDX_WRITE_PROT, 8'h00);
		rd(wpvr_pkg::IDX_CLK_MODE_B, 8'h20);
		wr(wpvr_pkg::IDX_CLK_MODE_A, 8'h5a);
		wr(wpvr_pkg::IDX_DET_ENABLE, 8'he0);
		wr(wpvr_pkg::IDX_PROG_GUARD, 8'h5a);
		rd(wpvr_pkg::IDX_CLK_MODE_A, 8'h00);
		chk({5'h0, det_enable_o}, 8'h00);
		chk(prog_guard_o, 8'h00);
		rd(6'h3f, 8'h00);
	endtask
	// Protect bit 0 opens the clock group; bits 3 and 6 open their groups and leave it locked
	task t_unlock;
		logic [5:0] ck [6];
		ck = '{wpvr_pkg::IDX_CLK_MODE_A, wpvr_pkg::IDX_CLK_MODE_B, wpvr_pkg::IDX_CLK_MODE_C,
			wpvr_pkg::IDX_MULT_CTRL, wpvr_pkg::IDX_PERIPH_CLK, wpvr_pkg::IDX_OSC_ADJUST};
		wr(wpvr_pkg::IDX_WRITE_PROT, 8'h01);
		foreach (ck[i]) wr(ck[i], 8'h33);
		foreach (ck[i]) rd(ck[i], 8'h33);
		chk(clk_mode_b_o, 8'h33);
		chk(clk_mode_c_o, 8'h33);
		chk(mult_ctrl_o, 8'h33);
		chk(periph_clk_o, 8'h33);
		chk(osc_adjust_o, 8'h33);
		wr(wpvr_pkg::IDX_WRITE_PROT, 8'h48);
		wr(wpvr_pkg::IDX_CLK_MODE_A, 8'h77);
		chk(clk_mode_a_o, 8'h33);
		wr(wpvr_pkg::IDX_PROG_GUARD, 8'h5c);
		chk(prog_guard_o, 8'h5c);
		wb_sel_i <= 4'h0;
		wr(wpvr_pkg::IDX_PROG_GUARD, 8'h11);
		wb_sel_i <= 4'h1;
		chk(prog_guard_o, 8'h5c);
		wr(wpvr_pkg::IDX_LEVEL_SEL, 8'h03);
		chk(level_sel_o, 8'h03);
	endtask
	// Comparator level, then reset and interrupt requests
	task vl(input logic [2:0] v, input logic [1:0] e);
		volt_low_i <= v;
		repeat (4) @(posedge clk_i);
		chk({6'h0, volt_reset_req_o, volt_irq_o}, {6'h0, e});
	endtask
	task t_volt;
		wr(wpvr_pkg::IDX_MON0_CTRL, 8'h01);
		wr(wpvr_pkg::IDX_MON1_CTRL, 8'h01);
		wr(wpvr_pkg::IDX_MON2_CTRL, 8'h03);
		wr(wpvr_pkg::IDX_DET_ENABLE, 8'he0);
		chk({5'h0, det_enable_o}, 8'h07);
		vl(3'b010, 2'b01);
		vl(3'b100, 2'b10);
		vl(3'b001, 2'b10);
		wr(wpvr_pkg::IDX_DET_ENABLE, 8'h20);
		chk({5'h0, det_enable_o}, 8'h01);
		vl(3'b110, 2'b00);
		vl(3'b000, 2'b00);
	endtask
	// Pulse one cause line and let it pass the synchroniser
	task cause(input logic [3:0] c);
		{wdog_expire_i, osc_stop_i, pin_reset_i, por_i} <= c;
		repeat (4) @(posedge clk_i);
		{wdog_expire_i, osc_stop_i, pin_reset_i, por_i} <= 4'h0;
		repeat (4) @(posedge clk_i);
	endtask
	// Cause recording, software request, warm reset keeps flags
	task t_src;
		logic [7:0] ex [3];
		ex = '{8'h81, 8'ha0, 8'hc0};
		cause(4'b0001);
		rd(wpvr_pkg::IDX_RESET_SRC, 8'h10);
		for (int k = 0; k < 3; k++) begin
			cause(4'b0010 << k);
			rd(wpvr_pkg::IDX_RESET_SRC, ex[k]);
		end
		vl(3'b001, 2'b10);
		rd(wpvr_pkg::IDX_RESET_SRC, 8'h82);
		vl(3'b000, 2'b00);
		wr(wpvr_pkg::IDX_RESET_SRC, wpvr_pkg::SW_RESET_KEY);
		repeat (3) @(posedge clk_i);
		chk({7'h0, sw_seen}, 8'h01);
		rd(wpvr_pkg::IDX_RESET_SRC, 8'h80);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(wpvr_pkg::IDX_RESET_SRC, 8'h80);
	endtask
	task results;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_lock;
		t_unlock;
		t_volt;
		t_src;
		results;
	end
	// Hang guard
	initial begin
		repeat (3000) @(posedge clk_i);
		error_cnt++;
		results;
	end
endmodule
bind wpvr_regs wpvr_regs_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .det_enable_o, .volt_reset_req_o, .volt_irq_o, .sw_reset_req_o, .clk_mode_a_o, .prog_guard_o);
`default_nettype wire
